// [core/ars_pkg.sv]
// Package for the converter reference and input selection block.
// Assumes one system clock; every user names items as ars_pkg::name.
package ars_pkg;

    // Reference select field codes.
    localparam logic [1:0] REF_SEL_PIN_LDO = 2'h0;
    localparam logic [1:0] REF_SEL_AVDD_A  = 2'h1;
    localparam logic [1:0] REF_SEL_TSV     = 2'h2;
    localparam logic [1:0] REF_SEL_AVDD_B  = 2'h3;

    // Share field value that hands the shared pin to the reference input.
    localparam logic [1:0] SHARE_VREF      = 2'h2;
    localparam int         SHARE_VREF_MSB  = 7;
    localparam int         SHARE_VREF_LSB  = 6;

    // Regulator voltage codes usable as a reference: 010, 011 and 11x.
    localparam logic [2:0] REGV_A          = 3'h2;
    localparam logic [2:0] REGV_B          = 3'h3;
    localparam logic [1:0] REGV_HI_TOP     = 2'h3;

    // Input source select codes.
    localparam logic [2:0] INS_EXT0        = 3'h0;
    localparam logic [2:0] INS_BANDGAP     = 3'h1;
    localparam logic [2:0] INS_TSO         = 3'h2;
    localparam logic [2:0] INS_OPOUT       = 3'h3;
    localparam logic [2:0] INS_OPP         = 3'h4;
    localparam logic [2:0] INS_EXT5        = 3'h5;
    localparam logic [2:0] INS_EXT6        = 3'h6;
    localparam logic [2:0] INS_FORBID      = 3'h7;

    // Channel count and pin reset values.
    localparam int         NUM_CH          = 8;
    localparam logic [7:0] PIN_OE_N_RST    = 8'hFF;
    localparam logic [7:0] PIN_ZERO        = 8'h00;

    // Control fields held by the block.
    typedef struct packed {
        logic [1:0] ref_source_sel;
        logic [1:0] port_b_share_low;
        logic       regulator_path_switch;
        logic [2:0] regulator_voltage_sel;
        logic       temp_sensor_enable;
        logic [2:0] input_source_sel;
        logic [3:0] channel_sel;
    } ars_ctrl_t;

    localparam ars_ctrl_t CTRL_RST = '0;

    // One-hot reference source in use.
    typedef enum logic [4:0] {
        REF_NONE = 5'h01,
        REF_PIN  = 5'h02,
        REF_LDO  = 5'h04,
        REF_AVDD = 5'h08,
        REF_TSV  = 5'h10
    } ars_ref_kind_t;

    // One-hot converter input route.
    typedef enum logic [5:0] {
        ROUTE_FLOAT = 6'h01,
        ROUTE_EXT   = 6'h02,
        ROUTE_BG    = 6'h04,
        ROUTE_TSO   = 6'h08,
        ROUTE_OPOUT = 6'h10,
        ROUTE_OPP   = 6'h20
    } ars_route_t;

    // Reference decoder results.
    typedef struct packed {
        ars_ref_kind_t kind;
        logic          ldo_path_en;
        logic          vref_pin_func_en;
        logic          conflict;
    } ars_ref_t;

endpackage

// [core/ars_ref_sel.sv]
// Reference source decoder, purely combinational.
// Assumes its control fields come straight from registers.
`timescale 1ns/1ns
module ars_ref_sel (
    input  wire ars_pkg::ars_ctrl_t ctrl, // Registered control fields.
    output ars_pkg::ars_ref_t       refo  // Decoded reference switches.
);
    logic share_vref;
    logic regv_ok;
    logic sw;

    // Field qualifiers for the reference choices; regv_ok gates only the regulator one.
    assign share_vref = ctrl.port_b_share_low == ars_pkg::SHARE_VREF; // RQ3
    assign sw         = ctrl.regulator_path_switch;
    assign regv_ok    = ctrl.regulator_voltage_sel == ars_pkg::REGV_A
                     || ctrl.regulator_voltage_sel == ars_pkg::REGV_B
                     || ctrl.regulator_voltage_sel[2:1] == ars_pkg::REGV_HI_TOP; // RQ6

    // Picks exactly one reference; unsafe mixes select none.
    always_comb begin
        refo.kind             = ars_pkg::REF_NONE;
        refo.ldo_path_en      = sw; // RQ5
        refo.vref_pin_func_en = share_vref; // RQ3
        case (ctrl.ref_source_sel) // RQ1
            ars_pkg::REF_SEL_PIN_LDO: begin
                if (share_vref && !sw) begin
                    refo.kind = ars_pkg::REF_PIN; // RQ2
                end else if (!share_vref && sw && regv_ok) begin
                    refo.kind = ars_pkg::REF_LDO; // RQ2 RQ6
                end
            end
            ars_pkg::REF_SEL_AVDD_A, ars_pkg::REF_SEL_AVDD_B: begin
                if (!share_vref && !sw) begin
                    refo.kind = ars_pkg::REF_AVDD; // RQ8
                end
            end
            ars_pkg::REF_SEL_TSV: begin
                if (ctrl.temp_sensor_enable && !share_vref && !sw) begin
                    refo.kind = ars_pkg::REF_TSV; // RQ9
                end
            end
            default: begin
                refo.kind = ars_pkg::REF_NONE;
            end
        endcase
        // Flags a setup that would tie two references together.
        refo.conflict = (share_vref && sw)
                     || (ctrl.ref_source_sel != ars_pkg::REF_SEL_PIN_LDO
                         && (share_vref || sw)); // RQ10
    end
endmodule

// [core/ars_pin_ctl.sv]
// Per-pin control of the eight analog channel pins.
// Assumes pad inputs are asynchronous and the other inputs share mclk.
`timescale 1ns/1ns
module ars_pin_ctl (
    input  wire logic       mclk,         // System clock.
    input  wire logic       reset_n,      // Asynchronous reset, active low.
    input  wire logic [7:0] an_share_en,  // Pin handed to the converter.
    input  wire logic [7:0] port_dir_in,  // Port direction, 1 is input.
    input  wire logic [7:0] pullup_req,   // Software pull-up enables.
    input  wire logic [7:0] gpio_out,     // Digital output data.
    input  wire logic [7:0] pad_in,       // Pad level seen from outside.
    output logic      [7:0] pad_out,      // Pad drive data.
    output logic      [7:0] pad_oe_n,     // Pad drive enable, low drives.
    output logic      [7:0] pullup_on,    // Pull-up actually connected.
    output logic      [7:0] gpio_in       // Filtered digital input.
);
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] din;
        logic [7:0] dout;
        logic [7:0] oe_n;
        logic [7:0] pu;
    } ars_pin_state_t;

    ars_pin_state_t st_q;
    ars_pin_state_t st_d;
    logic [7:0]     digital;

    // Analog use disables every digital function of the pin.
    assign digital = ~an_share_en; // RQ11

    // Next state: three-stage sync, then pad control.
    always_comb begin
        st_d      = st_q;
        st_d.s1   = pad_in;
        st_d.s2   = st_q.s1;
        st_d.s3   = st_q.s2;
        st_d.din  = ((st_q.s2 & st_q.s3) | (st_q.din & (st_q.s2 ^ st_q.s3))) & digital; // RQ11
        st_d.dout = gpio_out & digital; // RQ11
        st_d.oe_n = ~(digital & ~port_dir_in); // RQ13
        st_d.pu   = pullup_req & digital; // RQ12
    end

    // State register.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q      <= '0;
            st_q.oe_n <= ars_pkg::PIN_OE_N_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign pad_out   = st_q.dout;
    assign pad_oe_n  = st_q.oe_n;
    assign pullup_on = st_q.pu;
    assign gpio_in   = st_q.din;
endmodule

// [core/ars_top.sv]
// Contract
// [RQ1] Reference source follows the two-bit select, qualified by share, switch, sensor bits.
// [RQ2] Select 00 routes the reference pin or the regulator output.
// [RQ3] Share field 10 in port B share bits 7:6 enables the reference pin.
// [RQ4] Software clears the regulator switch when using the reference pin.
// [RQ5] Regulator switch high connects regulator output to the reference; low cuts it.
// [RQ6] Regulator voltage codes 010, 011, 11x are the only usable reference levels.
// [RQ7] Software keeps the share field off 10 when using the regulator.
// [RQ8] Select 01 and 11 both route the analog supply.
// [RQ9] Select 10 routes the sensor reference; sensor enable must be set first.
// [RQ10] For supply or sensor reference, software keeps switch cleared and share off 10.
// [RQ11] A pin used as analog channel loses all its other functions.
// [RQ12] Pull-ups drop automatically on pins used as analog inputs.
// [RQ13] Analog pin use overrides the port direction setting.
// [RQ14] Input codes 000, 101, 110 pick an external channel by channel field.
// [RQ15] Channel 0000-0111 picks pins 0-7; 1000-1111 leaves the input floating.
// [RQ16] Codes 001-100 pick bandgap, sensor output, op-amp output, op-amp input.
// [RQ17] With an internal source, software sets channel field to 1000-1111.
// [RQ18] Software never writes 111 into the input source field.
// [RQ19] Switch enables are exclusive, decoded from registers, valid the cycle after write.
//
// Top of the reference and input selection block.
// Assumes software writes all control fields at once with a one-cycle strobe.
`timescale 1ns/1ns
module ars_top (
    input  wire logic               mclk,          // System clock, 50 MHz.
    input  wire logic               reset_n,       // Asynchronous reset, active low.
    input  wire logic               cfg_wr,        // Control write strobe.
    input  wire ars_pkg::ars_ctrl_t cfg_d,         // Control write data.
    input  wire logic [7:0]         an_share_en,   // Pin share bits for channels.
    input  wire logic [7:0]         port_dir_in,   // Port direction, 1 is input.
    input  wire logic [7:0]         pullup_req,    // Software pull-up enables.
    input  wire logic [7:0]         gpio_out,      // Digital output data.
    input  wire logic [7:0]         pad_in,        // Pad levels.
    output logic      [7:0]         pad_out,       // Pad drive data.
    output logic      [7:0]         pad_oe_n,      // Pad drive enable, low drives.
    output logic      [7:0]         pullup_on,     // Pull-ups connected.
    output logic      [7:0]         gpio_in,       // Digital input data.
    output ars_pkg::ars_ctrl_t      ctrl_q,        // Control readback.
    output ars_pkg::ars_ref_kind_t  ref_kind,      // Reference switch in use.
    output logic                    ldo_path_en,   // Regulator path switch.
    output logic                    vref_pin_func, // Reference pin function on.
    output logic                    ref_conflict,  // References would collide.
    output ars_pkg::ars_route_t     input_route,   // Converter input route.
    output logic      [7:0]         ext_ch_en,     // External channel switches.
    output logic                    input_conflict,// Pin and internal mix.
    output logic                    write_refused  // Forbidden input code seen.
);
    typedef struct packed {
        ars_pkg::ars_ctrl_t ctrl;
        logic               refused;
    } ars_top_state_t;

    ars_top_state_t    st_q;
    ars_top_state_t    st_d;
    ars_pkg::ars_ref_t refo;
    logic              internal;

    // Takes a control write; a forbidden input code keeps the old field.
    always_comb begin
        st_d         = st_q;
        st_d.refused = 1'b0;
        if (cfg_wr) begin
            st_d.ctrl = cfg_d; // RQ19
            if (cfg_d.input_source_sel == ars_pkg::INS_FORBID) begin
                st_d.ctrl.input_source_sel = st_q.ctrl.input_source_sel; // RQ18
                st_d.refused               = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.ctrl <= ars_pkg::CTRL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign ctrl_q        = st_q.ctrl;
    assign write_refused = st_q.refused;

    // Reference decoder on the registered fields.
    ars_ref_sel u_ref (
        .ctrl (st_q.ctrl),
        .refo (refo)
    );

    assign ref_kind      = refo.kind; // RQ19
    assign ldo_path_en   = refo.ldo_path_en;
    assign vref_pin_func = refo.vref_pin_func_en;
    assign ref_conflict  = refo.conflict;

    // Input route decoder; on an external code a channel code above seven leaves it floating.
    always_comb begin
        input_route = ars_pkg::ROUTE_FLOAT;
        case (st_q.ctrl.input_source_sel)
            ars_pkg::INS_EXT0, ars_pkg::INS_EXT5, ars_pkg::INS_EXT6: begin
                if (st_q.ctrl.channel_sel[3]) begin
                    input_route = ars_pkg::ROUTE_FLOAT; // RQ15
                end else begin
                    input_route = ars_pkg::ROUTE_EXT; // RQ14
                end
            end
            ars_pkg::INS_BANDGAP: begin
                input_route = ars_pkg::ROUTE_BG; // RQ16
            end
            ars_pkg::INS_TSO: begin
                input_route = ars_pkg::ROUTE_TSO; // RQ16
            end
            ars_pkg::INS_OPOUT: begin
                input_route = ars_pkg::ROUTE_OPOUT; // RQ16
            end
            ars_pkg::INS_OPP: begin
                input_route = ars_pkg::ROUTE_OPP; // RQ16
            end
            default: begin
                input_route = ars_pkg::ROUTE_FLOAT;
            end
        endcase
    end

    // One channel switch per pin, closed only on an external route.
    genvar gi;
    generate
        for (gi = 0; gi < ars_pkg::NUM_CH; gi++) begin : g_ch
            assign ext_ch_en[gi] = (input_route == ars_pkg::ROUTE_EXT)
                && (st_q.ctrl.channel_sel[2:0] == 3'(gi)); // RQ15
        end
    endgenerate

    // Internal source with a real channel code would short pin and signal.
    assign internal       = (input_route != ars_pkg::ROUTE_EXT)
                         && (input_route != ars_pkg::ROUTE_FLOAT);
    assign input_conflict = internal && !st_q.ctrl.channel_sel[3]; // RQ17

    // Pin control for the eight channel pins.
    ars_pin_ctl u_pin (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .an_share_en (an_share_en),
        .port_dir_in (port_dir_in),
        .pullup_req  (pullup_req),
        .gpio_out    (gpio_out),
        .pad_in      (pad_in),
        .pad_out     (pad_out),
        .pad_oe_n    (pad_oe_n),
        .pullup_on   (pullup_on),
        .gpio_in     (gpio_in)
    );

    // Checks on the decoded switches and pin control.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // A legal control write, and one carrying the forbidden input code.
    sequence s_good_write;
        cfg_wr && cfg_d.input_source_sel != ars_pkg::INS_FORBID;
    endsequence

    sequence s_bad_write;
        cfg_wr && cfg_d.input_source_sel == ars_pkg::INS_FORBID;
    endsequence

    a_write_takes_effect: assert property ( // RQ19
        s_good_write |=> ctrl_q == $past(cfg_d))
        else $error("Control write not visible the next cycle.");

    a_forbid_refused: assert property ( // RQ18
        s_bad_write |=> write_refused
            && ctrl_q.input_source_sel == $past(ctrl_q.input_source_sel))
        else $error("Forbidden input code was not refused.");

    a_ref_pin_route: assert property ( // RQ2
        s_good_write ##0 (cfg_d.ref_source_sel == ars_pkg::REF_SEL_PIN_LDO
            && cfg_d.port_b_share_low == ars_pkg::SHARE_VREF
            && !cfg_d.regulator_path_switch)
        |=> ref_kind == ars_pkg::REF_PIN && vref_pin_func)
        else $error("Reference pin not routed.");

    a_ldo_route_level: assert property ( // RQ6
        ref_kind == ars_pkg::REF_LDO |-> ldo_path_en
            && (ctrl_q.regulator_voltage_sel == ars_pkg::REGV_A
                || ctrl_q.regulator_voltage_sel == ars_pkg::REGV_B
                || ctrl_q.regulator_voltage_sel[2:1] == ars_pkg::REGV_HI_TOP))
        else $error("Regulator reference with an unusable level.");

    a_ldo_bad_level: assert property ( // RQ6
        (ctrl_q.ref_source_sel == ars_pkg::REF_SEL_PIN_LDO
            && ctrl_q.regulator_path_switch
            && ctrl_q.port_b_share_low != ars_pkg::SHARE_VREF
            && ctrl_q.regulator_voltage_sel[2:1] == 2'h0)
        |-> ref_kind == ars_pkg::REF_NONE)
        else $error("Regulator reference accepted at a bad level.");

    a_path_switch_cut: assert property ( // RQ5
        cfg_wr && !cfg_d.regulator_path_switch |=> !ldo_path_en ##1 1'b1)
        else $error("Regulator path not cut after clear.");

    a_avdd_route: assert property ( // RQ8
        (ctrl_q.ref_source_sel[0]
            && ctrl_q.port_b_share_low != ars_pkg::SHARE_VREF
            && !ctrl_q.regulator_path_switch)
        |-> ref_kind == ars_pkg::REF_AVDD)
        else $error("Analog supply not routed for select 01 or 11.");

    a_tsv_needs_enable: assert property ( // RQ9
        ref_kind == ars_pkg::REF_TSV
        |-> ctrl_q.temp_sensor_enable
            && ctrl_q.ref_source_sel == ars_pkg::REF_SEL_TSV)
        else $error("Sensor reference routed without its enable.");

    a_ref_exclusive: assert property ( // RQ19
        $onehot(ref_kind) && $onehot(input_route))
        else $error("Reference or input switches not exclusive.");

    a_ext_channel_pick: assert property ( // RQ15
        input_route == ars_pkg::ROUTE_EXT
        |-> ext_ch_en == (8'h01 << ctrl_q.channel_sel[2:0]))
        else $error("Wrong external channel switch closed.");

    a_internal_no_pin: assert property ( // RQ16
        s_good_write ##0 (cfg_d.input_source_sel == ars_pkg::INS_BANDGAP)
        |=> input_route == ars_pkg::ROUTE_BG && ext_ch_en == 8'h00)
        else $error("Bandgap route wrong or a pin switch closed.");

    a_analog_pin_quiet: assert property ( // RQ12
        1'b1 |=> (pullup_on & $past(an_share_en)) == 8'h00
            && (~pad_oe_n & $past(an_share_en)) == 8'h00)
        else $error("Analog pin still pulled up or driven.");

    // A supply or sensor reference with the pin or regulator also on is flagged, never routed.
    a_mix_flagged: assert property ( // RQ10
        (ctrl_q.ref_source_sel != ars_pkg::REF_SEL_PIN_LDO
            && (vref_pin_func || ldo_path_en))
        |-> ref_conflict && ref_kind == ars_pkg::REF_NONE)
        else $error("Mixed references not flagged.");

    // Analog pins neither read nor drive digital data.
    a_analog_no_digital: assert property ( // RQ11
        1'b1 |=> (gpio_in & $past(an_share_en)) == 8'h00
            && (pad_out & $past(an_share_en)) == 8'h00)
        else $error("Analog pin still carries digital data.");

    // Drive enable follows direction on digital pins and is off on analog pins.
    a_dir_override: assert property ( // RQ13
        1'b1 |=> pad_oe_n == ($past(an_share_en) | $past(port_dir_in)))
        else $error("Pin drive enable ignores analog override.");

    // External codes with a real channel always close the channel route.
    a_ext_code_route: assert property ( // RQ14
        ((ctrl_q.input_source_sel == ars_pkg::INS_EXT0
            || ctrl_q.input_source_sel == ars_pkg::INS_EXT5
            || ctrl_q.input_source_sel == ars_pkg::INS_EXT6)
            && !ctrl_q.channel_sel[3])
        |-> input_route == ars_pkg::ROUTE_EXT)
        else $error("External code did not route a channel.");

    // Internal codes never close a pin switch and flag a real channel code.
    a_internal_flagged: assert property ( // RQ17
        (ctrl_q.input_source_sel >= ars_pkg::INS_BANDGAP
            && ctrl_q.input_source_sel <= ars_pkg::INS_OPP)
        |-> ext_ch_en == 8'h00 && input_conflict == !ctrl_q.channel_sel[3])
        else $error("Internal source with pin switch or missed flag.");

endmodule

// [bench/ars_top_bench.sv]
// Self-checking bench for the converter reference and input selection block.
// Assumes the design sources and ars_pkg are compiled first; one 50 MHz clock.
`timescale 1ns/1ns
module ars_top_bench;
    logic                   mclk;
    logic                   reset_n;
    logic                   cfg_wr;
    ars_pkg::ars_ctrl_t     cfg_d;
    logic [7:0]             an_share_en;
    logic [7:0]             port_dir_in;
    logic [7:0]             pullup_req;
    logic [7:0]             gpio_out;
    logic [7:0]             pad_in;
    logic [7:0]             pad_out;
    logic [7:0]             pad_oe_n;
    logic [7:0]             pullup_on;
    logic [7:0]             gpio_in;
    ars_pkg::ars_ctrl_t     ctrl_q;
    ars_pkg::ars_ref_kind_t ref_kind;
    logic                   ldo_path_en;
    logic                   vref_pin_func;
    logic                   ref_conflict;
    ars_pkg::ars_route_t    input_route;
    logic [7:0]             ext_ch_en;
    logic                   input_conflict;
    logic                   write_refused;
    ars_pkg::ars_ctrl_t     exp_c;
    ars_pkg::ars_ctrl_t     c;
    int                     fails;
    int                     total_checks;

    // Device under test.
    ars_top dut_u (
        .mclk           (mclk),
        .reset_n        (reset_n),
        .cfg_wr         (cfg_wr),
        .cfg_d          (cfg_d),
        .an_share_en    (an_share_en),
        .port_dir_in    (port_dir_in),
        .pullup_req     (pullup_req),
        .gpio_out       (gpio_out),
        .pad_in         (pad_in),
        .pad_out        (pad_out),
        .pad_oe_n       (pad_oe_n),
        .pullup_on      (pullup_on),
        .gpio_in        (gpio_in),
        .ctrl_q         (ctrl_q),
        .ref_kind       (ref_kind),
        .ldo_path_en    (ldo_path_en),
        .vref_pin_func  (vref_pin_func),
        .ref_conflict   (ref_conflict),
        .input_route    (input_route),
        .ext_ch_en      (ext_ch_en),
        .input_conflict (input_conflict),
        .write_refused  (write_refused)
    );

    // Free-running clock, 20 ns period.
    always #10 mclk = ~mclk;

    // Compares one value and counts it; a mismatch is reported at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic final_report;
        if (fails == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Expected reference switch from the control fields alone.
    function automatic logic [4:0] ref_of(input ars_pkg::ars_ctrl_t x);
        logic pin_sh;
        logic lvl_ok;
        pin_sh = (x.port_b_share_low == 2'h2);
        lvl_ok = (x.regulator_voltage_sel == 3'h2) || (x.regulator_voltage_sel == 3'h3) ||
                 (x.regulator_voltage_sel[2:1] == 2'h3);
        ref_of = 5'h01;
        case (x.ref_source_sel)
            2'h0: begin
                if (pin_sh && !x.regulator_path_switch) begin
                    ref_of = 5'h02;
                end else if (!pin_sh && x.regulator_path_switch && lvl_ok) begin
                    ref_of = 5'h04;
                end
            end
            2'h2: begin
                if (x.temp_sensor_enable && !pin_sh && !x.regulator_path_switch) begin
                    ref_of = 5'h10;
                end
            end
            default: begin
                if (!pin_sh && !x.regulator_path_switch) begin
                    ref_of = 5'h08;
                end
            end
        endcase
    endfunction

    // Expected converter input route from the control fields alone.
    function automatic logic [5:0] route_of(input ars_pkg::ars_ctrl_t x);
        case (x.input_source_sel)
            3'h1: route_of = 6'h04;
            3'h2: route_of = 6'h08;
            3'h3: route_of = 6'h10;
            3'h4: route_of = 6'h20;
            default: route_of = x.channel_sel[3] ? 6'h01 : 6'h02;
        endcase
    endfunction

    // Compares every decoded output against the mirror of the control fields.
    task automatic check_all;
        logic       ext;
        logic       sh;
        logic       sw;
        logic       cf;
        logic [7:0] ech;
        ext = (exp_c.input_source_sel == 3'h0) || (exp_c.input_source_sel == 3'h5) ||
              (exp_c.input_source_sel == 3'h6);
        sh  = (exp_c.port_b_share_low == 2'h2);
        sw  = exp_c.regulator_path_switch;
        cf  = (sh && sw) || (exp_c.ref_source_sel != 2'h0 && (sh || sw));
        ech = (ext && !exp_c.channel_sel[3]) ? 8'h01 << exp_c.channel_sel[2:0] : 8'h00;
        check(ctrl_q, exp_c, "ctrl_q");
        check(ref_kind, ref_of(exp_c), "ref_kind");
        check(ldo_path_en, sw, "ldo_path_en");
        check(vref_pin_func, sh, "vref_pin_func");
        check(ref_conflict, cf, "ref_conflict");
        check(input_route, route_of(exp_c), "input_route");
        check(ext_ch_en, ech, "ext_ch_en");
        check(input_conflict, !ext && !exp_c.channel_sel[3], "input_conflict");
    endtask

    // One control write; the strobe stays high so writes can run back to back.
    task automatic write_ctrl(input ars_pkg::ars_ctrl_t x);
        logic [2:0] keep;
        keep   = exp_c.input_source_sel;
        cfg_wr = 1'b1;
        cfg_d  = x;
        exp_c  = x;
        if (x.input_source_sel == 3'h7) begin
            exp_c.input_source_sel = keep;
        end
        @(negedge mclk);
        check_all();
        check(write_refused, x.input_source_sel == 3'h7, "write_refused");
    endtask

    // Drives one pin pattern and checks the one-cycle and synchronised answers.
    task automatic pin_case(input logic [7:0] sh, input logic [7:0] dir,
                            input logic [7:0] pu, input logic [7:0] go, input logic [7:0] pd);
        an_share_en = sh;
        port_dir_in = dir;
        pullup_req  = pu;
        gpio_out    = go;
        pad_in      = pd;
        @(negedge mclk);
        check(pad_out, go & ~sh, "pad_out");
        check(pad_oe_n, sh | dir, "pad_oe_n");
        check(pullup_on, pu & ~sh, "pullup_on");
        repeat (5) @(negedge mclk);
        check(gpio_in, pd & ~sh, "gpio_in");
    endtask

    // Main sequence.
    initial begin
        mclk         = 1'b0;
        reset_n      = 1'b0;
        cfg_wr       = 1'b0;
        cfg_d        = '0;
        an_share_en  = 8'h00;
        port_dir_in  = 8'h00;
        pullup_req   = 8'hFF;
        gpio_out     = 8'hFF;
        pad_in       = 8'hFF;
        exp_c        = '0;
        fails        = 0;
        total_checks = 0;
        repeat (8) @(negedge mclk);
        // Values held while reset is asserted.
        check_all();
        check(pad_oe_n, 8'hFF, "pad_oe_n reset");
        check(pad_out | pullup_on | gpio_in, 8'h00, "pins reset");
        check(write_refused, 1'b0, "write_refused reset");
        reset_n = 1'b1;
        // Every combination of the reference fields, written back to back.
        for (int i = 0; i < 512; i++) begin
            c                       = '0;
            c.ref_source_sel        = i[1:0];
            c.port_b_share_low      = i[3:2];
            c.regulator_path_switch = i[4];
            c.regulator_voltage_sel = i[7:5];
            c.temp_sensor_enable    = i[8];
            write_ctrl(c);
        end
        // Legal setups written the way software must write them.
        c                       = '0;
        c.port_b_share_low      = 2'h2;
        write_ctrl(c);
        c.port_b_share_low      = 2'h0;
        c.regulator_path_switch = 1'b1;
        c.regulator_voltage_sel = 3'h6;
        write_ctrl(c);
        c                       = '0;
        c.temp_sensor_enable    = 1'b1;
        write_ctrl(c);
        c.ref_source_sel        = 2'h2;
        write_ctrl(c);
        // Every legal input code against every channel value.
        for (int i = 0; i < 112; i++) begin
            c                  = '0;
            c.input_source_sel = i[6:4];
            c.channel_sel      = i[3:0];
            write_ctrl(c);
        end
        // Forbidden input code keeps the old field and flags the write.
        c                  = '0;
        c.input_source_sel = 3'h3;
        c.channel_sel      = 4'h8;
        write_ctrl(c);
        c.input_source_sel = 3'h7;
        c.ref_source_sel   = 2'h1;
        c.channel_sel      = 4'h9;
        write_ctrl(c);
        c.channel_sel      = 4'h2;
        write_ctrl(c);
        c.input_source_sel = 3'h5;
        write_ctrl(c);
        cfg_wr = 1'b0;
        @(negedge mclk);
        check(write_refused, 1'b0, "write_refused idle");
        check_all();
        // Pin sharing against direction, pull-ups and output data.
        pin_case(8'h00, 8'h0F, 8'hFF, 8'hA5, 8'h3C);
        pin_case(8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF);
        pin_case(8'h81, 8'h00, 8'hC3, 8'h5A, 8'hF0);
        pin_case(8'h3C, 8'hF0, 8'h0F, 8'hFF, 8'h0F);
        final_report();
    end

    // Watchdog: the tests need well under 1000 cycles.
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        final_report();
    end
endmodule
